// File: rtl/vsst_defines.svh
// Offsets, field positions, reset values and timing counts of the sample strobe block
`ifndef VSST_DEFINES_SVH
`define VSST_DEFINES_SVH
`define VSST_ADDR_W 4
`define VSST_REG_CTRL 4'h0
`define VSST_REG_STATUS 4'h4
`define VSST_REG_LAST 4'h8
`define VSST_CTRL_CDS 0
`define VSST_CTRL_TWO_CH 1
`define VSST_CTRL_CH_SEL 2
`define VSST_CTRL_OUT_DIS 3
`define VSST_CTRL_RESET 32'h0000_0003
`define VSST_LATENCY 7
`define VSST_PIPE_DEPTH 8
`define VSST_DATA_W 10
`endif

// File: rtl/vsst_pkg.sv
// Types of the sample strobe block
package vsst_pkg;
  typedef struct packed {
    logic correlated_double_sampling;
    logic two_ch;
    logic ch_sel;
    logic out_dis;
  } vsst_ctrl_t;
  typedef struct packed {
    logic video_cap;
    logic reset_cap;
    logic clamp;
    logic [1:0] ch_power;
  } vsst_analog_t;
  typedef enum logic [1:0] {VSST_IDLE, VSST_VIDEO, VSST_WAIT_RST} vsst_phase_t;
endpackage

// File: rtl/vsst_core.sv
// Pixel sample strobe timing and output latency control
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
`include "vsst_defines.svh"
// What this block does
// - Video strobe high closes the video-level sampling switch.
// - Reset strobe high closes the reset-level sampling switch.
// - Converted pixel word appears seven clocks after first rise past strobe fall.
// - In single-sample mode reset strobe drives input clamping instead.
// - Two-channel mode samples both inputs and converts both each pixel.
// - One-channel mode converts only the chosen input, other channel off.
// - Output bus floats when output enable pin or disable bit asks.
module vsst_core #(
  parameter int LATENCY = `VSST_LATENCY,
  parameter int DATA_W = `VSST_DATA_W
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // Avalon-MM slave
  input wire logic [`VSST_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Sensor strobes and converter data
  input wire logic video_sample_strobe_in,
  input wire logic reset_sample_strobe_in,
  input wire logic output_enable_pin_n_in,
  input wire logic [DATA_W-1:0] adc_ch0_in,
  input wire logic [DATA_W-1:0] adc_ch1_in,
  // Analog switch controls
  output vsst_pkg::vsst_analog_t analog_out,
  // Pixel output bus, three signals
  output logic [DATA_W-1:0] pixel_output_bus_out,
  output logic pixel_output_bus_oe_out,
  output logic pixel_valid_out
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    vsst_pkg::vsst_ctrl_t ctrl;
    vsst_pkg::vsst_phase_t phase;
    logic vs_d;
    logic [LATENCY-1:0] vld_pipe;
    logic [LATENCY-1:0][2*DATA_W-1:0] dat_pipe;
    logic [LATENCY-1:0] two_pipe;
    logic half;
    logic [2*DATA_W-1:0] pending;
    logic [2*DATA_W-1:0] last;
    logic [31:0] pixel_count;
    vsst_pkg::vsst_analog_t analog;
    logic [DATA_W-1:0] bus;
    logic bus_oe;
    logic valid;
    logic [31:0] rdata;
    logic wait_req;
  } vsst_state_t;
  vsst_state_t st;
  vsst_state_t next_st;
  // Control word after reset, split into fields at reset time
  localparam logic [31:0] CTRL_RST = `VSST_CTRL_RESET;
  // Strobe fall seen: high at the last edge, low now
  logic vs_fall;
  assign vs_fall = st.vs_d & ~video_sample_strobe_in;
  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.vs_d = video_sample_strobe_in;
    next_st.valid = 1'b0;
    // Sampling switches follow strobes
    next_st.analog.video_cap = video_sample_strobe_in;
    next_st.analog.reset_cap = st.ctrl.correlated_double_sampling & reset_sample_strobe_in;
    next_st.analog.clamp = ~st.ctrl.correlated_double_sampling & reset_sample_strobe_in;
    // Channel power: both in two-channel mode, else only the chosen one
    next_st.analog.ch_power = st.ctrl.two_ch ? 2'b11
      : (st.ctrl.ch_sel ? 2'b10 : 2'b01);
    // Strobe phase tracker
    case (st.phase)
      vsst_pkg::VSST_IDLE: begin
        if (video_sample_strobe_in) begin
          next_st.phase = vsst_pkg::VSST_VIDEO;
        end
      end
      vsst_pkg::VSST_VIDEO: begin
        if (!video_sample_strobe_in) begin
          next_st.phase = vsst_pkg::VSST_WAIT_RST;
        end
      end
      vsst_pkg::VSST_WAIT_RST: begin
        next_st.phase = video_sample_strobe_in ? vsst_pkg::VSST_VIDEO : vsst_pkg::VSST_IDLE;
      end
      default: begin
        next_st.phase = vsst_pkg::VSST_IDLE;
      end
    endcase
    // Latency pipeline, launched at first rise after strobe fall
    next_st.vld_pipe = {st.vld_pipe[LATENCY-2:0], vs_fall};
    next_st.two_pipe = {st.two_pipe[LATENCY-2:0], st.ctrl.two_ch};
    next_st.dat_pipe = {st.dat_pipe[LATENCY-2:0], {adc_ch1_in, adc_ch0_in}};
    if (vs_fall) begin
      next_st.pixel_count = st.pixel_count + 32'h0000_0001;
    end
    // Output word; second channel follows in the next cycle
    if (st.vld_pipe[LATENCY-1]) begin
      next_st.valid = 1'b1;
      if (st.two_pipe[LATENCY-1]) begin
        next_st.bus = st.dat_pipe[LATENCY-1][DATA_W-1:0];
        next_st.pending = st.dat_pipe[LATENCY-1];
        next_st.half = 1'b1;
      end else begin
        next_st.bus = st.ctrl.ch_sel ? st.dat_pipe[LATENCY-1][2*DATA_W-1:DATA_W]
          : st.dat_pipe[LATENCY-1][DATA_W-1:0];
      end
      next_st.last = st.dat_pipe[LATENCY-1];
    end else if (st.half) begin
      next_st.valid = 1'b1;
      next_st.bus = st.pending[2*DATA_W-1:DATA_W];
      next_st.half = 1'b0;
    end
    // Bus floats on pin or bit
    next_st.bus_oe = ~output_enable_pin_n_in & ~st.ctrl.out_dis;
    // Register bus: waitrequest from a flop, low for one cycle after each request
    // A write lands only at the edge that sees waitrequest low
    next_st.wait_req = ~((avs_read_in | avs_write_in) & st.wait_req);
    if (avs_write_in && !st.wait_req && avs_address_in == `VSST_REG_CTRL) begin
      next_st.ctrl.correlated_double_sampling = avs_writedata_in[`VSST_CTRL_CDS];
      next_st.ctrl.two_ch = avs_writedata_in[`VSST_CTRL_TWO_CH];
      next_st.ctrl.ch_sel = avs_writedata_in[`VSST_CTRL_CH_SEL];
      next_st.ctrl.out_dis = avs_writedata_in[`VSST_CTRL_OUT_DIS];
    end
    case (avs_address_in)
      `VSST_REG_CTRL: begin
        next_st.rdata = {28'h0000000, st.ctrl.out_dis, st.ctrl.ch_sel,
          st.ctrl.two_ch, st.ctrl.correlated_double_sampling};
      end
      `VSST_REG_STATUS: begin
        next_st.rdata = st.pixel_count;
      end
      `VSST_REG_LAST: begin
        next_st.rdata = 32'(st.last);
      end
      default: begin
        next_st.rdata = 32'h0000_0000;
      end
    endcase
    if (srst_in) begin
      next_st = '0;
      // Fields taken from their own bit places of the reset word
      next_st.ctrl.correlated_double_sampling = CTRL_RST[`VSST_CTRL_CDS];
      next_st.ctrl.two_ch = CTRL_RST[`VSST_CTRL_TWO_CH];
      next_st.ctrl.ch_sel = CTRL_RST[`VSST_CTRL_CH_SEL];
      next_st.ctrl.out_dis = CTRL_RST[`VSST_CTRL_OUT_DIS];
      next_st.analog.ch_power = 2'b11;
      next_st.wait_req = 1'b1; // Idle bus holds waitrequest high
    end
  end
  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock_in) begin
    st <= next_st;
  end
  // Outputs from flops
  assign avs_readdata_out = st.rdata;
  assign avs_waitrequest_out = st.wait_req;
  assign analog_out = st.analog;
  assign pixel_output_bus_out = st.bus;
  assign pixel_output_bus_oe_out = st.bus_oe;
  assign pixel_valid_out = st.valid;
  // ****************************************
  // Checks
  // ****************************************
  sequence s_fall;
    $fell(video_sample_strobe_in);
  endsequence
  a_output_latency: assert property (@(posedge clock_in) disable iff (srst_in)
    s_fall ##0 !$past(srst_in) |-> ##(LATENCY+1) pixel_valid_out)
    else $error("pixel word not on time");
  a_video_switch: assert property (@(posedge clock_in) disable iff (srst_in)
    video_sample_strobe_in |=> analog_out.video_cap)
    else $error("video switch open");
  a_reset_switch: assert property (@(posedge clock_in) disable iff (srst_in)
    reset_sample_strobe_in && st.ctrl.correlated_double_sampling |=> analog_out.reset_cap)
    else $error("reset switch open");
  a_clamp_use: assert property (@(posedge clock_in) disable iff (srst_in)
    reset_sample_strobe_in && !st.ctrl.correlated_double_sampling |=> analog_out.clamp && !analog_out.reset_cap)
    else $error("clamp not driven by reset strobe");
  a_clamp_open: assert property (@(posedge clock_in) disable iff (srst_in)
    !reset_sample_strobe_in |=> !analog_out.clamp)
    else $error("clamp closed without reset strobe");
  a_reset_open: assert property (@(posedge clock_in) disable iff (srst_in)
    !reset_sample_strobe_in |=> !analog_out.reset_cap)
    else $error("reset switch closed without strobe");
  a_video_open: assert property (@(posedge clock_in) disable iff (srst_in)
    !video_sample_strobe_in |=> !analog_out.video_cap)
    else $error("video switch closed without strobe");
  a_two_power: assert property (@(posedge clock_in) disable iff (srst_in)
    st.ctrl.two_ch && $stable(st.ctrl) |=> analog_out.ch_power == 2'b11)
    else $error("channel off in two-channel mode");
  a_one_power: assert property (@(posedge clock_in) disable iff (srst_in)
    !st.ctrl.two_ch && $stable(st.ctrl) |=>
    analog_out.ch_power == {$past(st.ctrl.ch_sel), !$past(st.ctrl.ch_sel)})
    else $error("wrong channel powered");
  a_bus_float: assert property (@(posedge clock_in) disable iff (srst_in)
    output_enable_pin_n_in || st.ctrl.out_dis |=> !pixel_output_bus_oe_out)
    else $error("bus driven while disabled");
  a_bus_drive: assert property (@(posedge clock_in) disable iff (srst_in)
    !output_enable_pin_n_in && !st.ctrl.out_dis |=> pixel_output_bus_oe_out)
    else $error("bus floating while enabled");
  a_phase_fall: assert property (@(posedge clock_in) disable iff (srst_in)
    vs_fall |=> st.phase == vsst_pkg::VSST_WAIT_RST)
    else $error("strobe fall not tracked");
  a_second_word: assert property (@(posedge clock_in) disable iff (srst_in)
    pixel_valid_out && st.half |=> pixel_valid_out)
    else $error("second channel word missing");
endmodule

// File: dv/vsst_gen.sv
// Timing generator model: sample strobes and converter words
`timescale 1ns/1ns
module vsst_gen (
  // Clock and launch
  input wire logic clock_in,
  input wire logic fire_in,
  input wire logic [9:0] w0_in,
  input wire logic [9:0] w1_in,
  // Strobes and words
  output logic vs_out,
  output logic rs_out,
  output logic [9:0] a0_out,
  output logic [9:0] a1_out
);
  logic [1:0] ph;
  initial {ph, vs_out, rs_out, a0_out, a1_out} = '0;
  // Strobes launched from clock rises only
  always @(posedge clock_in) begin
    ph <= fire_in ? 2'h1 : ph + {1'h0, ph != 2'h0};
    vs_out <= fire_in;
    rs_out <= ph == 2'h2; // Rises after the fall past strobe drop, unequal gaps
    if (fire_in) begin
      {a1_out, a0_out} <= {w1_in, w0_in};
    end else if (ph == 2'h3) begin
      {a1_out, a0_out} <= ~{a1_out, a0_out}; // Words no longer held
    end
  end
endmodule

// File: dv/tb_vsst_core.sv
// Self-checking bench of the sample strobe block
`timescale 1ns/1ns
module tb_vsst_core;
  logic clk, srst, rd, wr, wt, vs, rs, oe_n, oe, vld, fire;
  logic [3:0] ad;
  logic [31:0] wd, rdata, q;
  logic [9:0] c0, c1, w0, w1, px;
  vsst_pkg::vsst_analog_t an;
  int failures, cmp_count;
  int cyc = 0;
  vsst_core i_vsst_core (.clock_in(clk), .srst_in(srst), .avs_address_in(ad),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wt), .video_sample_strobe_in(vs), .reset_sample_strobe_in(rs),
    .output_enable_pin_n_in(oe_n), .adc_ch0_in(c0), .adc_ch1_in(c1), .analog_out(an),
    .pixel_output_bus_out(px), .pixel_output_bus_oe_out(oe), .pixel_valid_out(vld));
  vsst_gen i_vsst_gen (.clock_in(clk), .fire_in(fire), .w0_in(w0), .w1_in(w1),
    .vs_out(vs), .rs_out(rs), .a0_out(c0), .a1_out(c1));
  // Clock and hang guard
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end
  // Compare and report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [1:0] exp_pw(input logic [3:0] m);
    return m[1] ? 2'h3 : (m[2] ? 2'h2 : 2'h1);
  endfunction
  // Bus cycle, held until waitrequest seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    ad <= a;
    wd <= d;
    do begin
      @(posedge clk);
    end while (wt !== 1'h0);
    q = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  // One pixel through the generator
  task pixel(input logic [3:0] m);
    @(posedge clk);
    fire <= 1'h1;
    w0 <= 10'($urandom);
    w1 <= 10'($urandom);
    @(posedge clk);
    fire <= 1'h0;
    @(posedge clk);
    #1 chk(an.video_cap, 1'h1);
    repeat (2) @(posedge clk);
    #1 chk({an.reset_cap, an.clamp}, m[0] ? 2'h2 : 2'h1);
    repeat (6) @(posedge clk);
    #1 chk({vld, px}, {1'h1, (m[1] || !m[2]) ? w0 : w1});
    if (m[1]) begin
      @(posedge clk);
      #1 chk({vld, px}, {1'h1, w1});
    end
  endtask
  task print_verdict();
    $display("compares %0d, failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {srst, rd, wr, fire, oe_n} = 5'h10;
    {ad, wd, w0, w1} = '0;
    void'($urandom(85998));
    repeat (6) @(posedge clk);
    srst <= 1'h0;
    bus(1'h0, 4'h0, 32'h0);
    chk(q, 32'h3); // Control reset value
    chk(an.ch_power, 2'h3);
    bus(1'h0, 4'hC, 32'h0);
    chk(q, 32'h0); // Unmapped place reads zero
    $display("reset test done");
    for (int m = 0; m < 8; m++) begin
      bus(1'h1, 4'h0, 32'(m));
      pixel(4'(m));
      chk(an.ch_power, exp_pw(4'(m)));
      bus(1'h0, 4'h8, 32'h0);
      chk(q, {12'h000, w1, w0});
      $display("mode %0d done", m);
    end
    bus(1'h0, 4'h4, 32'h0);
    chk(q, 32'h0000_0008);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      oe_n <= k[0];
      bus(1'h1, 4'h0, {28'h0, k[1], 3'h3});
      @(posedge clk);
      #1 chk(oe, !k[0] && !k[1]);
    end
    $display("output enable test done");
    print_verdict();
  end
endmodule
